// *** src/spd_decode_pkg.sv ***
package spd_decode_pkg;
   localparam logic [11:0] ADDR_STORE_BASE   = 12'h000;
   localparam logic [11:0] ADDR_CAS_MAP      = 12'h048;
   localparam logic [11:0] ADDR_STORE_LAST   = 12'h07c;
   localparam logic [11:0] ADDR_ACC2         = 12'h100;
   localparam logic [11:0] ADDR_CYC3         = 12'h104;
   localparam logic [11:0] ADDR_ACC3         = 12'h108;
   localparam logic [11:0] ADDR_TRP          = 12'h10c;
   localparam logic [11:0] ADDR_TRRD         = 12'h110;
   localparam logic [11:0] ADDR_TRCD         = 12'h114;
   localparam logic [11:0] ADDR_TRAS         = 12'h118;
   localparam logic [11:0] ADDR_DENSITY      = 12'h11c;
   localparam logic [11:0] ADDR_STATUS       = 12'h120;
   localparam logic [11:0] ADDR_LATENCY      = 12'h124;
   localparam int          STORE_WORDS       = 32;
   localparam int          IDX_ACC2          = 24;
   localparam int          IDX_CYC3          = 25;
   localparam int          IDX_ACC3          = 26;
   localparam int          IDX_TRP           = 27;
   localparam int          IDX_TRRD          = 28;
   localparam int          IDX_TRCD          = 29;
   localparam int          IDX_TRAS          = 30;
   localparam int          IDX_DENSITY       = 31;
   localparam int          IDX_CAS_MAP       = 18;
   localparam logic [7:0]  STORE_RESET       = 8'h00;
   localparam logic [7:0]  ROLLUP_BASE_NS    = 8'h0f;
   localparam logic [3:0]  ROLLUP_MAX_CODE   = 4'h3;
   localparam logic [9:0]  DENSITY_UNIT_MB   = 10'h004;
   localparam logic [1:0]  RESP_OKAY         = 2'b00;
   localparam logic [1:0]  RESP_SLVERR       = 2'b10;
   localparam logic [1:0]  RESP_DECERR       = 2'b11;
endpackage : spd_decode_pkg

// *** src/spd_timing_decode.sv ***
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
module spd_timing_decode (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic [2:0]  s_axi_awprot,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic [2:0]  s_axi_arprot,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   import spd_decode_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic [7:0]  store_q [STORE_WORDS];
   logic [11:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0]  wstrb_q;
   logic        aw_held_q;
   logic        w_held_q;
   logic        bvalid_q;
   logic [1:0]  bresp_q;
   logic        rvalid_q;
   logic [1:0]  rresp_q;
   logic [31:0] rdata_q;

   logic [7:0]  acc2_b;
   logic [7:0]  cyc3_b;
   logic [7:0]  acc3_b;
   logic [7:0]  density_b;
   logic [7:0]  cas_b;
   logic [7:0]  acc2_ns;
   logic [3:0]  acc2_tenth;
   logic [5:0]  cyc3_ns;
   logic [1:0]  cyc3_qtr;
   logic [5:0]  acc3_ns;
   logic [1:0]  acc3_qtr;
   logic [15:0] acc2_ps;
   logic [15:0] cyc3_ps;
   logic [15:0] acc3_ps;
   logic [7:0]  undef_flags;
   logic        density_empty;
   logic        density_single;
   logic [3:0]  density_count;
   logic [2:0]  cas_high;
   logic [2:0]  cas_second;
   logic [2:0]  cas_third;
   logic [9:0]  density_max_mb;

   assign acc2_b    = store_q[IDX_ACC2];
   assign cyc3_b    = store_q[IDX_CYC3];
   assign acc3_b    = store_q[IDX_ACC3];
   assign density_b = store_q[IDX_DENSITY];
   assign cas_b     = store_q[IDX_CAS_MAP];

   ////////////////////////////////////////////////////////////////////////
   // whole ns plus tenths; codes 1..3 roll up to 16..18 ns
   always_comb begin
      acc2_tenth = acc2_b[3:0];
      if (acc2_b[7:4] != 4'h0 && acc2_b[7:4] <= ROLLUP_MAX_CODE) begin
         acc2_ns = ROLLUP_BASE_NS + {4'h0, acc2_b[7:4]};
      end else begin
         acc2_ns = {4'h0, acc2_b[7:4]};
      end
      acc2_ps = 16'(acc2_ns * 1000) + 16'(acc2_tenth * 100);
   end

   assign cyc3_ns  = cyc3_b[7:2];
   assign cyc3_qtr = cyc3_b[1:0];
   assign acc3_ns  = acc3_b[7:2];
   assign acc3_qtr = acc3_b[1:0];
   assign cyc3_ps  = 16'(cyc3_ns * 1000) + 16'(cyc3_qtr * 250);
   assign acc3_ps  = 16'(acc3_ns * 1000) + 16'(acc3_qtr * 250);

   // checks start from the raw byte, not the split fields
   rollup_low_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      acc2_b[7:4] == 4'h1 |-> acc2_ps == 16'(16000 + acc2_b[3:0] * 100))
      else $error("rollup code not 16 ns");
   rollup_code_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      acc2_b[7:4] == 4'h2 |-> acc2_ps == 16'(17000 + acc2_b[3:0] * 100))
      else $error("rollup code not 17 ns");
   rollup_top_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      acc2_b[7:4] == 4'h3 |-> acc2_ps == 16'(18000 + acc2_b[3:0] * 100))
      else $error("rollup code not 18 ns");
   tenth_add_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      acc2_b[7:4] > 4'h3 |->
      acc2_ps == 16'(acc2_b[7:4] * 1000 + acc2_b[3:0] * 100))
      else $error("tenths not added");
   cycle_qtr_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      cyc3_ps == 16'(cyc3_b[7:2] * 1000 + cyc3_b[1:0] * 250))
      else $error("cycle quarter sum wrong");
   access_qtr_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      acc3_ps == 16'(acc3_b[7:2] * 1000 + acc3_b[1:0] * 250))
      else $error("access quarter sum wrong");

   // a zero whole-ns part sets its undef_flags bit; the time still reads from the byte, as zero for 8'h00
   assign undef_flags[0] = (acc2_b[7:4] == 4'h0);
   assign undef_flags[1] = (cyc3_ns == 6'h00);
   assign undef_flags[2] = (acc3_ns == 6'h00);
   assign undef_flags[3] = (store_q[IDX_TRP] == 8'h00);
   assign undef_flags[4] = (store_q[IDX_TRRD] == 8'h00);
   assign undef_flags[5] = (store_q[IDX_TRCD] == 8'h00);
   assign undef_flags[6] = (store_q[IDX_TRAS] == 8'h00);
   assign undef_flags[7] = 1'b0;

   undef_flag_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      undef_flags[6:3] == {store_q[IDX_TRAS] == 8'h00,
                           store_q[IDX_TRCD] == 8'h00,
                           store_q[IDX_TRRD] == 8'h00,
                           store_q[IDX_TRP] == 8'h00})
      else $error("undefined flag mismatch");
   undef_ns_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      undef_flags[2:0] == {acc3_b[7:2] == 6'h00, cyc3_b[7:2] == 6'h00,
                           acc2_b[7:4] == 4'h0})
      else $error("zero whole-ns part not flagged");

   ////////////////////////////////////////////////////////////////////////
   // density map: bit n is 4 MByte shifted by n
   always_comb begin
      density_count  = 4'h0;
      density_max_mb = 10'h000;
      for (int i = 0; i < 8; i++) begin
         density_count = density_count + {3'h0, density_b[i]};
         if (density_b[i]) begin
            density_max_mb = DENSITY_UNIT_MB << i;
         end
      end
   end
   // an empty map is malformed data; one bit means uniform rows
   assign density_empty  = (density_b == 8'h00);
   assign density_single = (density_count == 4'h1);

   density_one_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      density_single |-> $onehot(density_b) && !density_empty)
      else $error("single density bit wrong");
   density_max_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      density_b == 8'h0c |-> density_max_mb == 10'h020)
      else $error("density size wrong");
   density_top_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      density_b[7] |-> density_max_mb == 10'h200)
      else $error("top density bit not 512 MByte");
   density_cnt_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      density_count == 4'($countones(density_b)))
      else $error("density bit count wrong");
   density_none_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      density_empty == (density_b == 8'h00 && density_max_mb == 10'h000))
      else $error("empty density map not flagged");

   ////////////////////////////////////////////////////////////////////////
   // rank the supported latencies so software need not
   always_comb begin
      cas_high   = 3'h0;
      cas_second = 3'h0;
      cas_third  = 3'h0;
      for (int i = 0; i < 7; i++) begin
         if (cas_b[i]) begin
            cas_third  = cas_second;
            cas_second = cas_high;
            cas_high   = 3'(i + 1);
         end
      end
   end

   cas_rank_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      cas_b[6:0] != 7'h00 |->
      cas_b[cas_high - 3'h1] && (cas_b[6:0] >> cas_high) == 7'h00)
      else $error("highest latency rank wrong");
   cas_none_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      cas_b[6:0] == 7'h00 |-> cas_high == 3'h0 && cas_second == 3'h0)
      else $error("rank without latency");

   ////////////////////////////////////////////////////////////////////////
   // write path: address and data taken in either order
   logic wr_go;
   logic wr_in_store;
   assign wr_go         = aw_held_q && w_held_q && !bvalid_q;
   assign wr_in_store   = (awaddr_q <= ADDR_STORE_LAST);
   assign s_axi_awready = !aw_held_q && !bvalid_q;
   assign s_axi_wready  = !w_held_q && !bvalid_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         awaddr_q  <= 12'h000;
      end else if (s_axi_awvalid && s_axi_awready) begin
         aw_held_q <= 1'b1;
         awaddr_q  <= s_axi_awaddr;
      end else if (wr_go) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_q <= 1'b0;
         wdata_q  <= 32'h0000_0000;
         wstrb_q  <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         w_held_q <= 1'b1;
         wdata_q  <= s_axi_wdata;
         wstrb_q  <= s_axi_wstrb;
      end else if (wr_go) begin
         w_held_q <= 1'b0;
      end
   end

   // the store image is loaded by software; only lane 0 is kept
   generate
      for (genvar g = 0; g < STORE_WORDS; g++) begin : g_store
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               store_q[g] <= STORE_RESET;
            end else if (wr_go && wr_in_store && wstrb_q[0] &&
                         awaddr_q[6:2] == 5'(g)) begin
               store_q[g] <= wdata_q[7:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= RESP_OKAY;
      end else if (wr_go) begin
         bvalid_q <= 1'b1;
         if (wr_in_store) begin
            bresp_q <= RESP_OKAY;
         end else if (awaddr_q >= ADDR_ACC2 &&
                      awaddr_q <= ADDR_LATENCY) begin
            bresp_q <= RESP_SLVERR;
         end else begin
            bresp_q <= RESP_DECERR;
         end
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp  = bresp_q;

   ////////////////////////////////////////////////////////////////////////
   // read path: one cycle from address to data
   logic [31:0] rd_d;
   logic [1:0]  rresp_d;
   assign s_axi_arready = !rvalid_q;

   always_comb begin
      rd_d    = 32'h0000_0000;
      rresp_d = RESP_OKAY;
      if (s_axi_araddr <= ADDR_STORE_LAST) begin
         rd_d = {24'h00_0000, store_q[s_axi_araddr[6:2]]};
      end else begin
         unique case (s_axi_araddr)
            ADDR_ACC2:    rd_d = {16'h0000, acc2_ps};
            ADDR_CYC3:    rd_d = {16'h0000, cyc3_ps};
            ADDR_ACC3:    rd_d = {16'h0000, acc3_ps};
            ADDR_TRP:     rd_d = {24'h00_0000, store_q[IDX_TRP]};
            ADDR_TRRD:    rd_d = {24'h00_0000, store_q[IDX_TRRD]};
            ADDR_TRCD:    rd_d = {24'h00_0000, store_q[IDX_TRCD]};
            ADDR_TRAS:    rd_d = {24'h00_0000, store_q[IDX_TRAS]};
            ADDR_DENSITY: rd_d = {22'h00_0000, density_max_mb};
            ADDR_STATUS:  rd_d = {14'h0000, density_count, density_single,
                                  density_empty, 4'h0, undef_flags};
            ADDR_LATENCY: rd_d = {20'h0_0000, 1'b0, cas_third, 1'b0,
                                  cas_second, 1'b0, cas_high};
            default:      rresp_d = RESP_DECERR;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
         rresp_q  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rdata_q  <= rd_d;
         rresp_q  <= rresp_d;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata  = rdata_q;
   assign s_axi_rresp  = rresp_q;

   ////////////////////////////////////////////////////////////////////////
   // no answer may survive a reset
   reset_idle_a: assert property (
      @(posedge aclk) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid)
      else $error("answer pending after reset");
   read_answer_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   write_answer_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_go |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
      else $error("write answer late");
   write_ro_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_go && awaddr_q >= ADDR_ACC2 && awaddr_q <= ADDR_LATENCY |=>
      s_axi_bresp == RESP_SLVERR)
      else $error("decoded word accepted a write");
   write_err_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_go && awaddr_q > ADDR_LATENCY |=>
      s_axi_bresp == RESP_DECERR)
      else $error("unmapped write not refused");
   store_write_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      wr_go && wr_in_store && wstrb_q[0] |=>
      store_q[$past(awaddr_q[6:2])] == $past(wdata_q[7:0]))
      else $error("store byte not written");
   raw_spacing_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_TRRD |=>
      s_axi_rdata == {24'h00_0000, $past(store_q[IDX_TRRD])})
      else $error("activate spacing read wrong");
   raw_time_a: assert property (
      @(posedge aclk) disable iff (!aresetn)
      s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_TRAS |=>
      s_axi_rdata == {24'h00_0000, $past(store_q[IDX_TRAS])})
      else $error("activate-to-precharge read wrong");
endmodule : spd_timing_decode

// *** verification/host_model.sv ***
`timescale 1ns/10ps
module host_model (
   input  wire logic        aclk,
   output logic [11:0]      s_axi_awaddr,
   output logic [2:0]       s_axi_awprot,
   output logic             s_axi_awvalid,
   input  wire logic        s_axi_awready,
   output logic [31:0]      s_axi_wdata,
   output logic [3:0]       s_axi_wstrb,
   output logic             s_axi_wvalid,
   input  wire logic        s_axi_wready,
   input  wire logic [1:0]  s_axi_bresp,
   input  wire logic        s_axi_bvalid,
   output logic             s_axi_bready,
   output logic [11:0]      s_axi_araddr,
   output logic [2:0]       s_axi_arprot,
   output logic             s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic [31:0] s_axi_rdata,
   input  wire logic [1:0]  s_axi_rresp,
   input  wire logic        s_axi_rvalid,
   output logic             s_axi_rready
);
   initial begin
      {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata} = '0;
      {s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
   end
   // address and data offered together, each dropped once taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d,
                     output logic [1:0] r);
      bit aw;
      bit w;
      aw = 0;
      w = 0;
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : rd
endmodule : host_model

// *** verification/tb_top.sv ***
`timescale 1ns/10ps
module tb_top;
   import spd_decode_pkg::*;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [2:0]  s_axi_awprot, s_axi_arprot;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int bad_count, samples_checked;
   spd_timing_decode dut_u (.*);
   host_model host_u (.*);
   initial begin
      aclk = 0;
      forever #5 aclk = ~aclk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic final_report;
      if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report
   // tenths plus rollup of the first three codes
   function automatic logic [31:0] ps10(logic [7:0] b);
      logic [31:0] ns;
      ns = b[7:4];
      if (ns > 0 && ns < 4) ns = ns + 15;
      return ns * 1000 + b[3:0] * 100;
   endfunction : ps10
   function automatic logic [31:0] ps4(logic [7:0] b);
      return b[7:2] * 1000 + b[1:0] * 250;
   endfunction : ps4
   function automatic logic [31:0] rank(logic [7:0] c);
      logic [31:0] v;
      int k;
      v = 0;
      k = 0;
      for (int n = 6; n >= 0; n--) if (c[n] && k < 3) begin
         v = v | ((n + 1) << (4 * k));
         k++;
      end
      return v;
   endfunction : rank
   initial begin // watchdog sized well past the expected run
      #200_000;
      bad_count++;
      final_report();
   end
   initial begin
      logic [7:0]  b [8];
      logic [7:0]  cas;
      logic [31:0] e [10], g [10], d;
      logic [1:0]  r;
      int msb, cnt;
      aresetn = 0;
      d = $urandom(15225);
      repeat (8) @(posedge aclk);
      aresetn <= 1;
      host_u.rd(12'h060, d, r);
      chk(d, {24'h00_0000, STORE_RESET});
      for (int i = 0; i < 40; i++) begin
         foreach (b[k]) b[k] = 8'($urandom);
         b[0][3:0] = 4'($urandom_range(9));
         if (i < 4) b[0][7:4] = 4'(i); // low codes and rollup corners
         if (i == 1) {b[3], b[6], b[7]} = {8'hff, 8'h3c, 8'h0c};
         if (i == 0) b = '{default: 8'h00};
         if (i == 3) b[7] = 8'h08; // equal rows give one bit
         cas = 8'($urandom_range(127));
         if (i == 1) cas = 8'h07; // latencies 3, 2 and 1
         host_u.wr(ADDR_CAS_MAP, {24'($urandom), cas}, r);
         chk(r, RESP_OKAY);
         foreach (b[k]) begin
            host_u.wr(12'(12'h060 + 4 * k), {24'($urandom), b[k]}, r);
            chk(r, RESP_OKAY);
         end
         host_u.rd(12'h060 + 4 * (i % 8), d, r);
         chk(d, {24'h00_0000, b[i % 8]});
         msb = 0;
         for (int j = 0; j < 8; j++) if (b[7][j]) msb = j;
         cnt = $countones(b[7]);
         e = '{ps10(b[0]), ps4(b[1]), ps4(b[2]), b[3], b[4], b[5], b[6],
               4 << msb, 0, rank(cas)};
         e[8] = {b[6] == 0, b[5] == 0, b[4] == 0, b[3] == 0,
                 b[2][7:2] == 0, b[1][7:2] == 0, b[0][7:4] == 0};
         e[8] = e[8] | (b[7] == 0) << 12 | (cnt == 1) << 13 | cnt << 14;
         if (b[7] == 8'h00) e[7] = 0; // empty map names no row size
         for (int k = 0; k < 10; k++) begin
            host_u.rd(12'(ADDR_ACC2 + 4 * k), g[k], r);
            chk(r, RESP_OKAY);
         end
         // reserved status bits are not part of the contract
         g[8] = g[8] & 32'h0003_f07f;
         chk(g[0], e[0]);
         chk(g[1], e[1]);
         chk(g[2], e[2]);
         chk(g[3], e[3]);
         chk(g[4], e[4]);
         chk(g[5], e[5]);
         chk(g[6], e[6]);
         chk(g[7], e[7]);
         chk(g[8], e[8]);
         chk(g[9], e[9]);
      end
      // a mid-run reset must leave an empty store behind
      aresetn <= 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      host_u.rd(ADDR_STATUS, d, r);
      chk(d, 32'h0000_107f);
      host_u.rd(ADDR_DENSITY, d, r);
      chk(d, 32'h0000_0000);
      host_u.wr(12'h080, 32'h0000_0001, r);
      chk(r, RESP_DECERR);
      host_u.rd(12'h080, d, r);
      chk(r, RESP_DECERR);
      host_u.wr(ADDR_TRAS, 32'h0000_0001, r);
      chk(r, RESP_SLVERR);
      host_u.wr(12'h200, 32'h0000_0001, r);
      chk(r, RESP_DECERR);
      host_u.rd(12'h200, d, r);
      chk(r, RESP_DECERR);
      final_report();
   end
endmodule : tb_top
